// File: adc_input_channel_select.sv
// Register block and input routing for the converter multiplexers
`timescale 1ns/1ps
module adc_input_channel_select #(
  parameter int NUM_INPUTS = 32,
  parameter bit SECOND_CONVERTER = 1'b0
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic SAMPLE_B_I,
  input wire logic SCAN_STEP_I,
  output logic [4:0] ZERO_POS_SEL_O,
  output logic ZERO_POS_REF_O,
  output logic ZERO_NEG_SEL_O,
  output logic [1:0] MULTI_NEG_GROUP_O,
  output logic MULTI_POS_SEL_O,
  output logic [31:0] SCAN_MASK_O,
  output logic [4:0] SCAN_INPUT_O,
  output logic SCAN_VALID_O,
  output logic SCAN_REF_O,
  output logic TWELVE_BIT_MODE_O
);
  // Number of inputs that really have a pin
  localparam logic [5:0] PIN_LIMIT = 6'(NUM_INPUTS);
  // Positive limit, narrower on the second converter
  localparam logic [5:0] POS_LIMIT = (SECOND_CONVERTER &&
      NUM_INPUTS > adc_sel_pkg::SECOND_LIMIT) ?
      6'(adc_sel_pkg::SECOND_LIMIT) : 6'(NUM_INPUTS);

  logic [15:0] multi_reg;
  logic [15:0] zero_reg;
  logic [15:0] scan_high_reg;
  logic [15:0] scan_low_reg;
  logic [15:0] ctrl_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic wr_fire;
  logic twelve_bit_mode;
  logic [15:0] multi_eff;
  logic [4:0] pos_code;
  logic neg_code;
  logic [1:0] mneg_code;
  logic mpos_code;
  logic [4:0] zero_pos_reg;
  logic zero_pos_ref_reg;
  logic zero_neg_reg;
  logic [1:0] multi_neg_reg;
  logic multi_pos_reg;
  logic [4:0] scan_input_reg;
  logic scan_valid_reg;
  logic scan_ref_reg;

  scan_if scan ();

  // True when an input index has no pin or is beyond a limit
  function automatic logic beyond(input logic [4:0] idx,
                                  input logic [5:0] limit);
    return ({1'b0, idx} >= limit);
  endfunction

  // Byte-lane merge of a 16-bit register, keeping unimplemented bits 0
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be,
                                          input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    return v & mask;
  endfunction

  // Multi-channel negative code to routed group
  function automatic logic [1:0] neg_group(input logic [1:0] code);
    case (code)
      adc_sel_pkg::NEG_CODE_HIGH: return adc_sel_pkg::NEG_GROUP_HIGH;
      adc_sel_pkg::NEG_CODE_LOW: return adc_sel_pkg::NEG_GROUP_LOW;
      default: return adc_sel_pkg::NEG_GROUP_REF;
    endcase
  endfunction

  // Read value of a register offset; unmapped reads zero
  function automatic logic [15:0] reg_read(input logic [7:0] a,
                                           input logic [15:0] mv,
                                           input logic [15:0] zv,
                                           input logic [15:0] hv,
                                           input logic [15:0] lv,
                                           input logic [15:0] cv);
    case (a)
      adc_sel_pkg::OFS_MULTI: return mv;
      adc_sel_pkg::OFS_ZERO: return zv;
      adc_sel_pkg::OFS_SCAN_HIGH: return hv;
      adc_sel_pkg::OFS_SCAN_LOW: return lv;
      adc_sel_pkg::OFS_CTRL: return cv;
      default: return adc_sel_pkg::RESET_VAL;
    endcase
  endfunction

  // One wait cycle per access, then the request completes
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
    end
  end

  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
  assign wr_fire = AVS_WRITE_I && ack_reg;
  assign twelve_bit_mode = ctrl_reg[adc_sel_pkg::CTRL_TWELVE_BIT];
  // Multi-channel fields vanish in twelve-bit mode
  assign multi_eff = twelve_bit_mode ? adc_sel_pkg::RESET_VAL
                                     : multi_reg;

  // Read data captured during the wait cycle
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_reg <= 32'h0000_0000;
    end else if (AVS_READ_I && !ack_reg) begin
      rdata_reg <= {16'h0000, reg_read(AVS_ADDRESS_I, multi_eff,
          zero_reg, scan_high_reg, scan_low_reg, ctrl_reg)};
    end
  end

  assign AVS_READDATA_O = rdata_reg;

  // Zero-channel select register, holes forced to zero
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      zero_reg <= adc_sel_pkg::RESET_VAL;
    end else if (wr_fire && AVS_ADDRESS_I == adc_sel_pkg::OFS_ZERO) begin
      zero_reg <= merge16(zero_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I,
                          adc_sel_pkg::ZERO_MASK);
    end
  end

  // Multi-channel select register, frozen in twelve-bit mode
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      multi_reg <= adc_sel_pkg::RESET_VAL;
    end else if (wr_fire && !twelve_bit_mode &&
                 AVS_ADDRESS_I == adc_sel_pkg::OFS_MULTI) begin
      multi_reg <= merge16(multi_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I,
                           adc_sel_pkg::MULTI_MASK);
    end
  end

  // Scan masks, every bit writable whatever the pin count
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scan_high_reg <= adc_sel_pkg::RESET_VAL;
      scan_low_reg <= adc_sel_pkg::RESET_VAL;
    end else if (wr_fire) begin
      if (AVS_ADDRESS_I == adc_sel_pkg::OFS_SCAN_HIGH) begin
        scan_high_reg <= merge16(scan_high_reg, AVS_WRITEDATA_I,
            AVS_BYTEENABLE_I, adc_sel_pkg::SCAN_MASK);
      end
      if (AVS_ADDRESS_I == adc_sel_pkg::OFS_SCAN_LOW) begin
        scan_low_reg <= merge16(scan_low_reg, AVS_WRITEDATA_I,
            AVS_BYTEENABLE_I, adc_sel_pkg::SCAN_MASK);
      end
    end
  end

  // Control register holding the resolution mode
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_reg <= adc_sel_pkg::RESET_VAL;
    end else if (wr_fire && AVS_ADDRESS_I == adc_sel_pkg::OFS_CTRL) begin
      ctrl_reg <= merge16(ctrl_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I,
                          adc_sel_pkg::CTRL_MASK);
    end
  end

  // Phase selection: sample B fields share the sample A decoding
  always_comb begin
    if (SAMPLE_B_I) begin
      pos_code = zero_reg[adc_sel_pkg::ZERO_POS_B_LSB +: 5];
      neg_code = zero_reg[adc_sel_pkg::ZERO_NEG_B_BIT];
      mneg_code = multi_eff[adc_sel_pkg::MULTI_NEG_B_LSB +: 2];
      mpos_code = multi_eff[adc_sel_pkg::MULTI_POS_B_BIT];
    end else begin
      pos_code = zero_reg[adc_sel_pkg::ZERO_POS_A_LSB +: 5];
      neg_code = zero_reg[adc_sel_pkg::ZERO_NEG_A_BIT];
      mneg_code = multi_eff[adc_sel_pkg::MULTI_NEG_A_LSB +: 2];
      mpos_code = multi_eff[adc_sel_pkg::MULTI_POS_A_BIT];
    end
  end

  // Registered multiplexer controls for channel 0
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      zero_pos_reg <= 5'h00;
      zero_pos_ref_reg <= 1'b0;
      zero_neg_reg <= 1'b0;
    end else begin
      zero_pos_reg <= pos_code;
      zero_pos_ref_reg <= beyond(pos_code, POS_LIMIT);
      zero_neg_reg <= neg_code;
    end
  end

  // Registered multiplexer controls for channels 1 to 3
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      multi_neg_reg <= adc_sel_pkg::NEG_GROUP_REF;
      multi_pos_reg <= 1'b0;
    end else begin
      multi_neg_reg <= neg_group(mneg_code);
      multi_pos_reg <= mpos_code;
    end
  end

  // Scan mask: high register covers inputs 16 to 31
  assign scan.mask = {scan_high_reg, scan_low_reg};
  assign scan.step = SCAN_STEP_I;

  scan_sequencer u_seq (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .scan(scan)
  );

  // Registered scan outputs; absent inputs convert the low reference
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scan_input_reg <= 5'h00;
      scan_valid_reg <= 1'b0;
      scan_ref_reg <= 1'b0;
    end else begin
      scan_input_reg <= scan.index;
      scan_valid_reg <= scan.valid;
      scan_ref_reg <= beyond(scan.index, PIN_LIMIT);
    end
  end

  assign ZERO_POS_SEL_O = zero_pos_reg;
  assign ZERO_POS_REF_O = zero_pos_ref_reg;
  assign ZERO_NEG_SEL_O = zero_neg_reg;
  assign MULTI_NEG_GROUP_O = multi_neg_reg;
  assign MULTI_POS_SEL_O = multi_pos_reg;
  assign SCAN_MASK_O = scan.mask;
  assign SCAN_INPUT_O = scan_input_reg;
  assign SCAN_VALID_O = scan_valid_reg;
  assign SCAN_REF_O = scan_ref_reg;
  assign TWELVE_BIT_MODE_O = twelve_bit_mode;

  // Checks on the routing and register behaviour
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  neg_a_route_a: assert property (
    !SAMPLE_B_I |=> ZERO_NEG_SEL_O ==
        $past(zero_reg[adc_sel_pkg::ZERO_NEG_A_BIT]))
    else $error("Sample A negative select wrong");

  neg_b_route_a: assert property (
    SAMPLE_B_I |=> ZERO_NEG_SEL_O ==
        $past(zero_reg[adc_sel_pkg::ZERO_NEG_B_BIT]))
    else $error("Sample B negative select wrong");

  pos_a_route_a: assert property (
    !SAMPLE_B_I |=> ZERO_POS_SEL_O == $past(zero_reg[4:0]))
    else $error("Sample A positive select wrong");

  pos_b_route_a: assert property (
    SAMPLE_B_I |=> ZERO_POS_SEL_O == $past(zero_reg[12:8]))
    else $error("Sample B positive select wrong");

  second_limit_a: assert property (
    (SECOND_CONVERTER && ZERO_POS_SEL_O[4]) |-> ZERO_POS_REF_O)
    else $error("Second converter routed a high positive input");

  holes_zero_a: assert property (
    (zero_reg & ~adc_sel_pkg::ZERO_MASK) == 16'h0000)
    else $error("Unimplemented select bits became set");

  scan_skip_a: assert property (
    SCAN_STEP_I |=> !scan.valid || $past(scan.mask[u_seq.found]))
    else $error("Scan reports an input that is skipped");

  scan_high_a: assert property (
    SCAN_MASK_O[31:16] == scan_high_reg)
    else $error("High scan bits mapped to wrong inputs");

  absent_ref_a: assert property (
    SCAN_VALID_O && ({1'b0, SCAN_INPUT_O} >= PIN_LIMIT)
        |-> SCAN_REF_O)
    else $error("Absent scan input not sent to reference");

  multi_neg_a: assert property (
    !SAMPLE_B_I && !twelve_bit_mode &&
        multi_reg[2:1] == adc_sel_pkg::NEG_CODE_HIGH
        |=> MULTI_NEG_GROUP_O == adc_sel_pkg::NEG_GROUP_HIGH)
    else $error("Multi negative high group not selected");

  twelve_zero_a: assert property (
    twelve_bit_mode |=> MULTI_NEG_GROUP_O == adc_sel_pkg::NEG_GROUP_REF
        && !MULTI_POS_SEL_O)
    else $error("Multi fields active in twelve-bit mode");

  wait_once_a: assert property (
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
        |=> !AVS_WAITREQUEST_O)
    else $error("Wait request held longer than one cycle");

  read_seen_c: cover property (AVS_READ_I && !AVS_WAITREQUEST_O);
  scan_wrap_c: cover property (SCAN_VALID_O && SCAN_INPUT_O == 5'h00
      ##1 SCAN_STEP_I);
  sample_b_c: cover property (SAMPLE_B_I ##1 ZERO_NEG_SEL_O);
  absent_c: cover property (SCAN_REF_O);
endmodule // adc_input_channel_select

// File: adc_sel_pkg.sv
// Constants, register map and types shared by the input select block
package adc_sel_pkg;
  // Register byte offsets on the Avalon slave
  localparam logic [7:0] OFS_MULTI = 8'h00;
  localparam logic [7:0] OFS_ZERO = 8'h04;
  localparam logic [7:0] OFS_SCAN_HIGH = 8'h08;
  localparam logic [7:0] OFS_SCAN_LOW = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  // Reset value of every field
  localparam logic [15:0] RESET_VAL = 16'h0000;
  // Implemented bits per register
  localparam logic [15:0] ZERO_MASK = 16'h9f9f;
  localparam logic [15:0] MULTI_MASK = 16'h0707;
  localparam logic [15:0] SCAN_MASK = 16'hffff;
  localparam logic [15:0] CTRL_MASK = 16'h0001;
  // Zero-channel field positions
  localparam int ZERO_NEG_B_BIT = 15;
  localparam int ZERO_POS_B_LSB = 8;
  localparam int ZERO_NEG_A_BIT = 7;
  localparam int ZERO_POS_A_LSB = 0;
  // Multi-channel field positions
  localparam int MULTI_NEG_B_LSB = 9;
  localparam int MULTI_POS_B_BIT = 8;
  localparam int MULTI_NEG_A_LSB = 1;
  localparam int MULTI_POS_A_BIT = 0;
  // Control register field
  localparam int CTRL_TWELVE_BIT = 0;
  // Input counts
  localparam int INPUT_COUNT = 32;
  localparam int SECOND_LIMIT = 16;
  localparam logic [4:0] LAST_INDEX = 5'h1f;
  // Multi-channel negative codes and routed groups
  localparam logic [1:0] NEG_CODE_HIGH = 2'h3;
  localparam logic [1:0] NEG_CODE_LOW = 2'h2;
  localparam logic [1:0] NEG_GROUP_REF = 2'h0;
  localparam logic [1:0] NEG_GROUP_LOW = 2'h1;
  localparam logic [1:0] NEG_GROUP_HIGH = 2'h2;
  // Scan sequencer states, Gray along idle, run, empty
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_RUN = 2'h1,
    SEQ_EMPTY = 2'h3
  } seq_state_e;
endpackage

// File: scan_if.sv
// Interface between the register block and the scan sequencer
`timescale 1ns/1ps
interface scan_if;
  logic [31:0] mask;
  logic step;
  logic [4:0] index;
  logic valid;
  modport ctrl (output mask, output step, input index, input valid);
  modport seq (input mask, input step, output index, output valid);
endinterface // scan_if

// File: scan_sequencer.sv
// Scan sequencer that walks the enabled analog inputs in order
`timescale 1ns/1ps
module scan_sequencer (
  input wire logic clk_i,
  input wire logic rst_i,
  scan_if.seq scan
);
  adc_sel_pkg::seq_state_e state_reg;
  adc_sel_pkg::seq_state_e state_next;
  logic [4:0] index_reg;
  logic [4:0] found;
  logic any;

  // Next enabled input after the given one, circularly
  function automatic logic [5:0] next_set(input logic [31:0] m,
                                          input logic [4:0] cur);
    logic [5:0] res;
    logic [4:0] cand;
    res = 6'h00;
    cand = cur;
    for (int k = 0; k < adc_sel_pkg::INPUT_COUNT; k++) begin
      cand = cand + 5'h01;
      if (m[cand] && !res[5]) begin
        res = {1'b1, cand};
      end
    end
    return res;
  endfunction

  // Search result for the next step
  always_comb begin
    {any, found} = next_set(scan.mask, index_reg);
  end

  // State transitions on each step request
  always_comb begin
    state_next = state_reg;
    if (scan.step) begin
      state_next = any ? adc_sel_pkg::SEQ_RUN : adc_sel_pkg::SEQ_EMPTY;
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= adc_sel_pkg::SEQ_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Current input; idle starts from the last so input 0 comes first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      index_reg <= adc_sel_pkg::LAST_INDEX;
    end else if (scan.step && any) begin
      index_reg <= found;
    end
  end

  assign scan.index = index_reg;
  assign scan.valid = (state_reg == adc_sel_pkg::SEQ_RUN);
endmodule // scan_sequencer

// File: testbench.sv
// Self-checking testbench for the converter input select block
`timescale 1ns/1ps
module testbench;
  logic CLK_I;
  logic RST_I;
  logic [7:0] AVS_ADDRESS_I;
  logic AVS_READ_I;
  logic AVS_WRITE_I;
  logic [31:0] AVS_WRITEDATA_I;
  logic [3:0] AVS_BYTEENABLE_I;
  logic [31:0] AVS_READDATA_O;
  logic AVS_WAITREQUEST_O;
  logic SAMPLE_B_I;
  logic SCAN_STEP_I;
  logic [4:0] ZERO_POS_SEL_O;
  logic ZERO_POS_REF_O;
  logic ZERO_NEG_SEL_O;
  logic [1:0] MULTI_NEG_GROUP_O;
  logic MULTI_POS_SEL_O;
  logic [31:0] SCAN_MASK_O;
  logic [4:0] SCAN_INPUT_O;
  logic SCAN_VALID_O;
  logic SCAN_REF_O;
  logic TWELVE_BIT_MODE_O;
  logic pos_ref_2;
  logic scan_ref_2;
  logic [31:0] rd_q;
  logic [15:0] v;
  logic [4:0] p;
  logic [2:0] f;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  int seq_tbl [5] = '{0, 2, 16, 31, 0};

  // Full-size first converter
  adc_input_channel_select u_adc_input_channel_select (
    .CLK_I(CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .SAMPLE_B_I(SAMPLE_B_I), .SCAN_STEP_I(SCAN_STEP_I),
    .ZERO_POS_SEL_O(ZERO_POS_SEL_O), .ZERO_POS_REF_O(ZERO_POS_REF_O),
    .ZERO_NEG_SEL_O(ZERO_NEG_SEL_O), .MULTI_NEG_GROUP_O(MULTI_NEG_GROUP_O),
    .MULTI_POS_SEL_O(MULTI_POS_SEL_O), .SCAN_MASK_O(SCAN_MASK_O),
    .SCAN_INPUT_O(SCAN_INPUT_O), .SCAN_VALID_O(SCAN_VALID_O),
    .SCAN_REF_O(SCAN_REF_O), .TWELVE_BIT_MODE_O(TWELVE_BIT_MODE_O));

  // Second converter with 20 pins, sharing the same bus traffic
  adc_input_channel_select #(.NUM_INPUTS(20), .SECOND_CONVERTER(1'b1))
    u_adc_input_channel_select_2 (
    .CLK_I(CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_READDATA_O(), .AVS_WAITREQUEST_O(),
    .SAMPLE_B_I(SAMPLE_B_I), .SCAN_STEP_I(SCAN_STEP_I),
    .ZERO_POS_SEL_O(), .ZERO_POS_REF_O(pos_ref_2), .ZERO_NEG_SEL_O(),
    .MULTI_NEG_GROUP_O(), .MULTI_POS_SEL_O(), .SCAN_MASK_O(),
    .SCAN_INPUT_O(), .SCAN_VALID_O(), .SCAN_REF_O(scan_ref_2),
    .TWELVE_BIT_MODE_O());

  // 125 MHz clock
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end

  // Prints counts and verdict, then stops
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cuts a hung run short
  always @(posedge CLK_I) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [7:0] a,
                     input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge CLK_I);
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= {16'h0000, d};
    AVS_BYTEENABLE_I <= be;
    AVS_READ_I <= rd;
    AVS_WRITE_I <= ~rd;
    do begin
      @(posedge CLK_I);
      n++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && n < 20);
    rd_q = AVS_READDATA_O;
    if (n >= 20) begin
      n_mismatch++;
      $display("ERROR waitrequest expected 0 seen %b", AVS_WAITREQUEST_O);
    end
    AVS_READ_I <= 1'b0;
    AVS_WRITE_I <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b0, a, d, 4'h3);
  endtask

  // Read and compare the whole 32-bit word, upper half zero
  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [15:0] exp);
    bus(1'b1, a, 16'h0000, 4'h3);
    chk(what, {16'h0000, exp}, rd_q);
  endtask

  // Selects the sample phase and lets the registered outputs settle
  task automatic put(input logic sb);
    @(posedge CLK_I);
    SAMPLE_B_I <= sb;
    repeat (3) @(posedge CLK_I);
    #1;
  endtask

  // One-cycle advance pulse, outputs looked at after they update
  task automatic step;
    @(posedge CLK_I);
    SCAN_STEP_I <= 1'b1;
    @(posedge CLK_I);
    SCAN_STEP_I <= 1'b0;
    @(posedge CLK_I);
    #1;
  endtask

  function automatic logic [1:0] grp(input logic [1:0] c);
    if (c == adc_sel_pkg::NEG_CODE_HIGH) return adc_sel_pkg::NEG_GROUP_HIGH;
    if (c == adc_sel_pkg::NEG_CODE_LOW) return adc_sel_pkg::NEG_GROUP_LOW;
    return adc_sel_pkg::NEG_GROUP_REF;
  endfunction

  // Main sequence
  initial begin
    RST_I = 1'b1;
    AVS_ADDRESS_I = 8'h00;
    AVS_READ_I = 1'b0;
    AVS_WRITE_I = 1'b0;
    AVS_WRITEDATA_I = 32'h00000000;
    AVS_BYTEENABLE_I = 4'h0;
    SAMPLE_B_I = 1'b0;
    SCAN_STEP_I = 1'b0;
    repeat (3) @(posedge CLK_I);
    RST_I <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rdc("reset value", 8'(i * 4), adc_sel_pkg::RESET_VAL);
    end
    chk("reset scan mask", 32'h00000000, SCAN_MASK_O);
    $display("Test reset values done");
    for (int n = 0; n < 32; n++) begin
      p = n[4:0];
      v = {~p[0], 2'b00, ~p, p[0], 2'b00, p};
      wr(adc_sel_pkg::OFS_ZERO, v | 16'h6060);
      rdc("zero readback", adc_sel_pkg::OFS_ZERO, v);
      put(1'b0);
      chk("zero pos a", {27'h0, p}, ZERO_POS_SEL_O);
      chk("zero neg a", {31'h0, p[0]}, ZERO_NEG_SEL_O);
      chk("zero ref a", 32'h0, ZERO_POS_REF_O);
      chk("second ref a", {31'h0, p[4]}, pos_ref_2);
      put(1'b1);
      chk("zero pos b", {27'h0, ~p}, ZERO_POS_SEL_O);
      chk("zero neg b", {31'h0, ~p[0]}, ZERO_NEG_SEL_O);
      chk("second ref b", {31'h0, ~p[4]}, pos_ref_2);
    end
    $display("Test channel zero done");
    for (int c = 0; c < 8; c++) begin
      f = c[2:0];
      v = {5'h00, ~f, 5'h00, f};
      wr(adc_sel_pkg::OFS_MULTI, v | 16'hf8f8);
      rdc("multi readback", adc_sel_pkg::OFS_MULTI, v);
      put(1'b0);
      chk("multi neg a", {30'h0, grp(f[2:1])}, MULTI_NEG_GROUP_O);
      chk("multi pos a", {31'h0, f[0]}, MULTI_POS_SEL_O);
      put(1'b1);
      chk("multi neg b", {30'h0, grp(~f[2:1])}, MULTI_NEG_GROUP_O);
      chk("multi pos b", {31'h0, ~f[0]}, MULTI_POS_SEL_O);
    end
    wr(adc_sel_pkg::OFS_CTRL, 16'hffff);
    rdc("control readback", adc_sel_pkg::OFS_CTRL, 16'h0001);
    put(1'b0);
    chk("twelve bit mode", 32'h1, TWELVE_BIT_MODE_O);
    rdc("multi in twelve bit", adc_sel_pkg::OFS_MULTI, 16'h0000);
    wr(adc_sel_pkg::OFS_CTRL, 16'h0000);
    put(1'b0);
    chk("twelve bit cleared", 32'h0, TWELVE_BIT_MODE_O);
    $display("Test multi channel done");
    wr(adc_sel_pkg::OFS_SCAN_HIGH, 16'h8001);
    wr(adc_sel_pkg::OFS_SCAN_LOW, 16'h0005);
    put(1'b0);
    chk("scan mask", 32'h80010005, SCAN_MASK_O);
    rdc("scan high", adc_sel_pkg::OFS_SCAN_HIGH, 16'h8001);
    for (int k = 0; k < 5; k++) begin
      step();
      chk("scan input", 32'(seq_tbl[k]), SCAN_INPUT_O);
      chk("scan valid", 32'h1, SCAN_VALID_O);
      chk("scan ref", 32'h0, SCAN_REF_O);
      chk("second scan ref", 32'(seq_tbl[k] >= 20), scan_ref_2);
    end
    bus(1'b0, adc_sel_pkg::OFS_SCAN_LOW, 16'hffff, 4'h1);
    rdc("scan low lane", adc_sel_pkg::OFS_SCAN_LOW, 16'h00ff);
    wr(adc_sel_pkg::OFS_SCAN_LOW, 16'h0000);
    wr(adc_sel_pkg::OFS_SCAN_HIGH, 16'h0000);
    step();
    chk("empty scan valid", 32'h0, SCAN_VALID_O);
    wr(adc_sel_pkg::OFS_SCAN_HIGH, 16'hffff);
    wr(adc_sel_pkg::OFS_SCAN_LOW, 16'hffff);
    rdc("scan high all", adc_sel_pkg::OFS_SCAN_HIGH, 16'hffff);
    rdc("scan low all", adc_sel_pkg::OFS_SCAN_LOW, 16'hffff);
    put(1'b0);
    chk("scan mask all", 32'hffffffff, SCAN_MASK_O);
    $display("Test scan select done");
    wr(8'h14, 16'hffff);
    rdc("unmapped read", 8'h14, 16'h0000);
    rdc("scan low after unmapped", adc_sel_pkg::OFS_SCAN_LOW, 16'hffff);
    $display("Test unmapped address done");
    wrap_up();
  end
endmodule // testbench
